/* src/crd_consts.svh */
// Offsets, codes, sizes and reset values of the crypto request decoder
`ifndef CRD_CONSTS_SVH
`define CRD_CONSTS_SVH
// Register byte offsets
`define CRD_OFF_CTRL 8'h00
`define CRD_OFF_FEAT 8'h04
`define CRD_OFF_OPCODE 8'h08
`define CRD_OFF_ALGO 8'h0c
`define CRD_OFF_HND_LO 8'h10
`define CRD_OFF_HND_HI 8'h14
`define CRD_OFF_FLAG 8'h18
`define CRD_OFF_PAD 8'h1c
`define CRD_OFF_FLF0 8'h20
`define CRD_OFF_FLF1 8'h24
`define CRD_OFF_FLF2 8'h28
`define CRD_OFF_FLF3 8'h2c
`define CRD_OFF_STATUS 8'h30
`define CRD_OFF_NEW_LO 8'h34
`define CRD_OFF_NEW_HI 8'h38
`define CRD_OFF_LAYOUT 8'h3c
`define CRD_OFF_SRC_LEN 8'h40
`define CRD_OFF_RES_LEN 8'h44
`define CRD_OFF_RES_OFF 8'h48
`define CRD_OFF_TRAILER 8'h4c
`define CRD_OFF_SUPPORT 8'h50
// Command codes in the control register
`define CRD_CMD_CREATE 2'h1
`define CRD_CMD_DESTROY 2'h2
`define CRD_CMD_DATA 2'h3
// Status byte codes
`define CRD_ST_OK 8'h00
`define CRD_ST_ERR 8'h01
`define CRD_ST_NOTSUPP 8'h02
`define CRD_ST_INVSESS 8'h03
`define CRD_ST_NOSPC 8'h04
// Service codes and opcode fields
`define CRD_SVC_CIPHER 8'h00
`define CRD_SVC_HASH 8'h01
`define CRD_SVC_MAC 8'h02
`define CRD_SVC_AEAD 8'h03
`define CRD_SVC_AKCIPHER 8'h04
`define CRD_OP_ENC 8'h00
`define CRD_OP_DEC 8'h01
`define CRD_OP_SIGN 8'h02
`define CRD_OP_VERIFY 8'h03
`define CRD_OPC_SVC_LSB 8
`define CRD_SESSION_MODE 32'h00000001
// Byte sizes of header and fixed blocks
`define CRD_HDR_LEN 32'h00000018
`define CRD_FLF_LEGACY 8'h30
`define CRD_FLF_HASH 8'h08
`define CRD_FLF_HASH_SL 8'h10
`define CRD_FLF_MAC 8'h08
`define CRD_FLF_MAC_SL 8'h10
`define CRD_FLF_OTHER 8'h30
// Reset values
`define CRD_RST_FEAT 6'h00
`define CRD_RST_SUPPORT 5'h1f
`define CRD_RST_STATUS 8'h00
`endif

/* src/crd_hdr_parser.sv */
// Opcode and feature decode that picks the fixed and variable block layout
`timescale 1ns/1ps
`default_nettype none
`include "crd_consts.svh"
module crd_hdr_parser
	import crd_pkg::*;
(
	crd_if.dec_mp d
);
	logic [7:0] svc_code;
	logic [7:0] op_idx;
	logic rev1;
	logic [4:0] sl_vec;
	logic flag_sess;

	// Service code and operation index share the opcode word
	assign svc_code = d.opcode[`CRD_OPC_SVC_LSB +: 8];
	assign op_idx = d.opcode[7:0];
	assign rev1 = d.feat[0];
	assign sl_vec = d.feat[5:1];
	assign flag_sess = (d.flag == `CRD_SESSION_MODE);

	// Layout choice by opcode and negotiated features
	always_comb
	begin
		d.svc_known = (svc_code <= `CRD_SVC_AKCIPHER) && (d.opcode[31:16] == 16'h0000);
		d.svc = svc_code[2:0];
		d.op_ok = 1'b0;
		case (svc_code)
			`CRD_SVC_CIPHER, `CRD_SVC_AEAD: d.op_ok = (op_idx <= `CRD_OP_DEC);
			`CRD_SVC_HASH, `CRD_SVC_MAC: d.op_ok = (op_idx == `CRD_OP_ENC);
			`CRD_SVC_AKCIPHER: d.op_ok = (op_idx <= `CRD_OP_VERIFY);
			default: d.op_ok = 1'b0;
		endcase
		d.op_ok = d.op_ok && d.svc_known;
		d.stateless = d.svc_known ? sl_vec[svc_code[2:0]] : 1'b0;
		// Flag only counts once revision one is on
		d.sess_mode = rev1 ? flag_sess : 1'b1;
		d.reject = rev1 && !d.stateless && !flag_sess;
		if (!rev1 && !d.stateless)
			d.flf_len = `CRD_FLF_LEGACY;
		else
		begin
			case (svc_code)
				`CRD_SVC_HASH: d.flf_len = d.stateless ? `CRD_FLF_HASH_SL : `CRD_FLF_HASH;
				`CRD_SVC_MAC: d.flf_len = d.stateless ? `CRD_FLF_MAC_SL : `CRD_FLF_MAC;
				default: d.flf_len = `CRD_FLF_OTHER;
			endcase
		end
	end
endmodule
`default_nettype wire

/* src/crd_if.sv */
// Carrier between the decoder top, the opcode parser and the session table
`timescale 1ns/1ps
`default_nettype none
interface crd_if;
	logic [31:0] opcode;
	logic [5:0] feat;
	logic [31:0] flag;
	logic svc_known;
	logic op_ok;
	logic [2:0] svc;
	logic stateless;
	logic sess_mode;
	logic reject;
	logic [7:0] flf_len;
	logic [63:0] handle;
	logic alloc_en;
	logic free_en;
	logic free_found;
	logic [63:0] alloc_handle;
	logic hit;

	modport top_mp (output opcode, feat, flag, handle, alloc_en, free_en,
		input svc_known, op_ok, svc, stateless, sess_mode, reject, flf_len,
		input free_found, alloc_handle, hit);
	modport dec_mp (input opcode, feat, flag,
		output svc_known, op_ok, svc, stateless, sess_mode, reject, flf_len);
	modport tbl_mp (input svc, handle, alloc_en, free_en,
		output free_found, alloc_handle, hit);
endinterface
`default_nettype wire

/* src/crd_pkg.sv */
// Types shared by the crypto request decoder modules
package crd_pkg;
	typedef enum logic [1:0] {
		CRD_IDLE = 2'b00,
		CRD_EXEC = 2'b01,
		CRD_ENG = 2'b10
	} crd_state_t;

	typedef struct packed {
		logic waitreq;
		logic [31:0] rdata;
		logic [5:0] feat;
		logic [4:0] support;
		logic [31:0] opcode;
		logic [31:0] algo;
		logic [63:0] handle;
		logic [31:0] flag;
		logic [3:0][31:0] flf;
		logic [7:0] status;
		logic busy;
		logic done;
		logic [63:0] new_handle;
		logic [31:0] src_len;
		logic [31:0] res_len;
		logic [31:0] res_off;
		logic [31:0] trailer;
		logic [7:0] flf_len;
		logic stateless;
		logic [2:0] svc;
		logic sess_mode;
		logic [1:0] cmd;
		crd_state_t state;
		logic eng_start;
	} crd_top_st_t;

	typedef struct packed {
		logic [7:0] valid;
		logic [7:0][2:0] svc;
		logic [7:0][15:0] seq;
		logic [15:0] ctr;
	} crd_tbl_st_t;
endpackage

/* src/crd_session_table.sv */
// Eight-entry session table that issues and checks session handles
`timescale 1ns/1ps
`default_nettype none
`include "crd_consts.svh"
module crd_session_table
	import crd_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	crd_if.tbl_mp t
);
	crd_tbl_st_t st_reg;
	crd_tbl_st_t st_next;
	logic [7:0] match;
	logic [2:0] free_idx;
	logic [2:0] h_idx;
	logic [15:0] h_seq;

	assign h_idx = t.handle[2:0];
	assign h_seq = t.handle[18:3];

	// Per-entry compare of the presented handle
	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_match
			assign match[i] = st_reg.valid[i] && (st_reg.seq[i] == h_seq) &&
				(st_reg.svc[i] == t.svc) && (h_idx == 3'(i));
		end
	endgenerate
	// Upper handle bits must be zero, so forged handles with high bits set miss; stale ones miss on the sequence compare
	assign t.hit = (|match) && (t.handle[63:19] == 45'h0);

	// Lowest free slot; sequence number keeps reused slots unique
	always_comb
	begin
		free_idx = 3'h0;
		t.free_found = 1'b0;
		for (int k = 7; k >= 0; k--)
		begin
			if (!st_reg.valid[k])
			begin
				free_idx = 3'(k);
				t.free_found = 1'b1;
			end
		end
		t.alloc_handle = {45'h0, st_reg.ctr, free_idx};
		st_next = st_reg;
		if (t.alloc_en && t.free_found)
		begin
			st_next.valid[free_idx] = 1'b1;
			st_next.seq[free_idx] = st_reg.ctr;
			st_next.svc[free_idx] = t.svc;
			st_next.ctr = st_reg.ctr + 16'h0001;
		end
		if (t.free_en && t.hit)
			st_next.valid[h_idx] = 1'b0;
	end

	// State register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st_reg <= '0;
		else if (ce)
			st_reg <= st_next;
	end
endmodule
`default_nettype wire

/* src/crd_top.sv */
// Crypto request decoder: register front end, command sequencer and engine hand-off
//
// Overview of operation
// - Pick the create parameter layout from the opcode's service code.
// - Read per-service fixed block fields at the offsets of the chosen layout.
// - Create reports success, unsupported, no-space, or generic error.
// - No free handle reports no-space only with revision one, else generic error.
// - New session handle is written only when create status is success.
// - Destroy reports success or generic error.
// - Header holds opcode, algorithm, 64-bit handle, flag, padding, little-endian.
// - Opcode is service code plus an operation index checked per service.
// - Flag value one means the request uses an existing session.
// - Without revision one the flag is ignored.
// - Revision one without stateless: requests lacking session flag are rejected.
// - Request is header, fixed block, variable block, then status trailer.
// - Without revision one the session fixed block is padded to 48 bytes.
// - Stateless layouts are used when the service's stateless feature is on.
// - Outcome goes in a one-byte status trailer at the request end.
// - Session hash fixed block: source length then result length.
// - Stateless hash fixed block: algorithm, source length, result length, reserved.
// - Session-mode request with an unknown handle reports invalid session.
// - On hash success the digest goes into the result area.
`timescale 1ns/1ps
`default_nettype none
`include "crd_consts.svh"
module crd_top
	import crd_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic eng_start,
	output logic [2:0] eng_service,
	output logic [31:0] eng_algo,
	output logic [31:0] eng_src_len,
	output logic [31:0] eng_res_len,
	output logic [31:0] eng_res_off,
	input wire logic eng_done,
	input wire logic eng_ok
);
	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------
	crd_if bus_if ();
	crd_top_st_t st_reg;
	crd_top_st_t st_next;

	crd_hdr_parser u_parser (
		.d(bus_if.dec_mp)
	);

	crd_session_table u_table (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.t(bus_if.tbl_mp)
	);

	// Byte-lane merge for every writable register except the control register
	function automatic logic [31:0] crd_merge(
		input logic [31:0] old_val,
		input logic [31:0] wdata,
		input logic [3:0] be
	);
		logic [31:0] r;
		// Disabled lanes keep old bytes
		r = old_val;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				r[b*8 +: 8] = wdata[b*8 +: 8];
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// Parser and table inputs
	// ------------------------------------------------------------
	assign bus_if.opcode = st_reg.opcode;
	assign bus_if.feat = st_reg.feat;
	assign bus_if.flag = st_reg.flag;
	assign bus_if.handle = st_reg.handle;

	// Exec lasts one cycle
	logic in_exec;
	logic svc_supported;
	assign in_exec = (st_reg.state == CRD_EXEC);
	assign svc_supported = st_reg.support[bus_if.svc];

	// Allocation only on a create that passed every earlier check
	assign bus_if.alloc_en = in_exec && (st_reg.cmd == `CRD_CMD_CREATE) &&
		bus_if.svc_known && svc_supported;
	assign bus_if.free_en = in_exec && (st_reg.cmd == `CRD_CMD_DESTROY);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	logic [31:0] rd_val;
	logic acc;

	// Layout-picked lengths
	logic [31:0] src_w;
	logic [31:0] res_w;
	logic [31:0] key_w;
	always_comb
	begin
		rd_val = 32'h0;
		src_w = 32'h0;
		res_w = 32'h0;
		key_w = 32'h0;
		st_next = st_reg;
		st_next.eng_start = 1'b0;
		acc = (avs_read || avs_write) && !st_reg.waitreq;

		// Read mux; unmapped and padding words read zero
		case (avs_address)
			`CRD_OFF_CTRL: rd_val = {29'h0, st_reg.cmd, st_reg.busy};
			`CRD_OFF_FEAT: rd_val = {26'h0, st_reg.feat};
			`CRD_OFF_OPCODE: rd_val = st_reg.opcode;
			`CRD_OFF_ALGO: rd_val = st_reg.algo;
			`CRD_OFF_HND_LO: rd_val = st_reg.handle[31:0];
			`CRD_OFF_HND_HI: rd_val = st_reg.handle[63:32];
			`CRD_OFF_FLAG: rd_val = st_reg.flag;
			`CRD_OFF_FLF0: rd_val = st_reg.flf[0];
			`CRD_OFF_FLF1: rd_val = st_reg.flf[1];
			`CRD_OFF_FLF2: rd_val = st_reg.flf[2];
			`CRD_OFF_FLF3: rd_val = st_reg.flf[3];
			`CRD_OFF_STATUS: rd_val = {22'h0, st_reg.done, st_reg.busy, st_reg.status};
			`CRD_OFF_NEW_LO: rd_val = st_reg.new_handle[31:0];
			`CRD_OFF_NEW_HI: rd_val = st_reg.new_handle[63:32];
			// Decoded layout for software
			`CRD_OFF_LAYOUT: rd_val = {19'h0, st_reg.sess_mode, st_reg.svc,
				st_reg.stateless, st_reg.flf_len};
			`CRD_OFF_SRC_LEN: rd_val = st_reg.src_len;
			`CRD_OFF_RES_LEN: rd_val = st_reg.res_len;
			`CRD_OFF_RES_OFF: rd_val = st_reg.res_off;
			`CRD_OFF_TRAILER: rd_val = st_reg.trailer;
			`CRD_OFF_SUPPORT: rd_val = {27'h0, st_reg.support};
			default: rd_val = 32'h0;
		endcase

		// One wait cycle, then a single ready cycle per request
		if (st_reg.waitreq && (avs_read || avs_write))
		begin
			st_next.waitreq = 1'b0;
			if (avs_read)
				// Stands in the ready cycle
				st_next.rdata = rd_val;
		end
		else
			st_next.waitreq = 1'b1;

		// Register writes take effect on the ready cycle
		if (acc && avs_write)
		begin
			case (avs_address)
				`CRD_OFF_CTRL:
				begin
					// Start is ignored while a command is in flight
					if (avs_byteenable[0] && avs_writedata[0] && !st_reg.busy)
					begin
						st_next.cmd = avs_writedata[2:1];
						st_next.busy = 1'b1;
						st_next.done = 1'b0;
						st_next.state = CRD_EXEC;
					end
				end
				`CRD_OFF_FEAT: st_next.feat = 6'(crd_merge({26'h0, st_reg.feat},
					avs_writedata, avs_byteenable));
				// Header words, little-endian 32-bit lanes
				`CRD_OFF_OPCODE: st_next.opcode = crd_merge(st_reg.opcode,
					avs_writedata, avs_byteenable);
				`CRD_OFF_ALGO: st_next.algo = crd_merge(st_reg.algo,
					avs_writedata, avs_byteenable);
				`CRD_OFF_HND_LO: st_next.handle[31:0] = crd_merge(st_reg.handle[31:0],
					avs_writedata, avs_byteenable);
				`CRD_OFF_HND_HI: st_next.handle[63:32] = crd_merge(st_reg.handle[63:32],
					avs_writedata, avs_byteenable);
				`CRD_OFF_FLAG: st_next.flag = crd_merge(st_reg.flag,
					avs_writedata, avs_byteenable);
				// Padding word is accepted and dropped
				`CRD_OFF_PAD: st_next.cmd = st_reg.cmd;
				// Fixed block words
				`CRD_OFF_FLF0: st_next.flf[0] = crd_merge(st_reg.flf[0],
					avs_writedata, avs_byteenable);
				`CRD_OFF_FLF1: st_next.flf[1] = crd_merge(st_reg.flf[1],
					avs_writedata, avs_byteenable);
				`CRD_OFF_FLF2: st_next.flf[2] = crd_merge(st_reg.flf[2],
					avs_writedata, avs_byteenable);
				`CRD_OFF_FLF3: st_next.flf[3] = crd_merge(st_reg.flf[3],
					avs_writedata, avs_byteenable);
				`CRD_OFF_SUPPORT: st_next.support = 5'(crd_merge({27'h0, st_reg.support},
					avs_writedata, avs_byteenable));
				default: st_next.cmd = st_reg.cmd;
			endcase
		end

		// Command sequencer
		case (st_reg.state)
			CRD_IDLE:
			begin
				st_next.busy = st_reg.busy;
			end

			CRD_EXEC:
			begin
				st_next.svc = bus_if.svc;
				st_next.state = CRD_IDLE;
				st_next.busy = 1'b0;
				st_next.done = 1'b1;
				case (st_reg.cmd)
					`CRD_CMD_CREATE:
					begin
						// Service code selects the parameter structure
						if (!bus_if.svc_known || !svc_supported)
							st_next.status = `CRD_ST_NOTSUPP;
						else if (!bus_if.free_found)
							st_next.status = st_reg.feat[0] ? `CRD_ST_NOSPC : `CRD_ST_ERR;
						else
						begin
							st_next.status = `CRD_ST_OK;
							st_next.new_handle = bus_if.alloc_handle;
						end
					end

					`CRD_CMD_DESTROY:
					begin
						// Handle must match a live session of the same service
						st_next.status = bus_if.hit ? `CRD_ST_OK : `CRD_ST_ERR;
					end

					// First failed check wins
					`CRD_CMD_DATA:
					begin
						st_next.stateless = bus_if.stateless;
						st_next.sess_mode = bus_if.sess_mode;
						st_next.flf_len = bus_if.flf_len;
						if (!bus_if.op_ok || !svc_supported)
							st_next.status = `CRD_ST_NOTSUPP;
						else if (bus_if.reject)
							st_next.status = `CRD_ST_ERR;
						else if (bus_if.sess_mode && !bus_if.hit)
							st_next.status = `CRD_ST_INVSESS;
						else
						begin
							// Field positions follow the selected layout
							if (bus_if.stateless && bus_if.svc == 3'(`CRD_SVC_HASH))
							begin
								src_w = st_reg.flf[1];
								res_w = st_reg.flf[2];
							end
							else if (bus_if.stateless && bus_if.svc == 3'(`CRD_SVC_MAC))
							begin
								key_w = st_reg.flf[1];
								src_w = st_reg.flf[2];
								res_w = st_reg.flf[3];
							end
							else
							begin
								src_w = st_reg.flf[0];
								res_w = st_reg.flf[1];
							end
							st_next.src_len = src_w;
							st_next.res_len = res_w;
							// Result area follows key and source bytes
							st_next.res_off = key_w + src_w;
							// Trailer sits after header, fixed and variable blocks
							st_next.trailer = `CRD_HDR_LEN + {24'h0, bus_if.flf_len} +
								key_w + src_w + res_w;
							st_next.eng_start = 1'b1;
							st_next.state = CRD_ENG;
							st_next.busy = 1'b1;
							st_next.done = 1'b0;
						end
					end

					// Code zero: no command
					default: st_next.status = `CRD_ST_ERR;
				endcase
			end

			CRD_ENG:
			begin
				// Engine writes the digest; only its verdict lands here
				if (eng_done)
				begin
					st_next.status = eng_ok ? `CRD_ST_OK : `CRD_ST_ERR;
					st_next.state = CRD_IDLE;
					st_next.busy = 1'b0;
					st_next.done = 1'b1;
				end
			end
			default:
			begin
				st_next.state = CRD_IDLE;
				st_next.busy = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			// Waits and idles in reset
			st_reg <= '0;
			st_reg.waitreq <= 1'b1;
			st_reg.feat <= `CRD_RST_FEAT;
			st_reg.support <= `CRD_RST_SUPPORT;
			st_reg.status <= `CRD_RST_STATUS;
			st_reg.state <= CRD_IDLE;
		end
		else if (ce)
			st_reg <= st_next;
	end

	// ------------------------------------------------------------
	// Outputs, all straight from the state register
	// ------------------------------------------------------------
	assign avs_readdata = st_reg.rdata;
	assign avs_waitrequest = st_reg.waitreq;
	assign eng_start = st_reg.eng_start;
	// eng_service holds until the next command, the lengths and offset until the next engine start; eng_algo follows the algorithm register
	assign eng_service = st_reg.svc;
	assign eng_algo = st_reg.algo;
	assign eng_src_len = st_reg.src_len;
	assign eng_res_len = st_reg.res_len;
	assign eng_res_off = st_reg.res_off;
endmodule
`default_nettype wire

/* tb/crd_eng_model.sv */
// Behavioural crypto engine that answers start pulses after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module crd_eng_model
(
	input wire logic clk,
	input wire logic rst,
	input wire logic eng_start,
	input wire logic [3:0] delay,
	input wire logic pass,
	output logic eng_done,
	output logic eng_ok
);
	// ----------------------------------------
	// Engine timing
	// ----------------------------------------
	logic run;
	logic [3:0] cnt;
	// Digest counts as written to the result area when done rises
	// Ok toggles outside done so a stale level never passes as an answer
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			{run, cnt, eng_done, eng_ok} <= '0;
		else if (eng_start)
			{run, cnt, eng_done} <= {1'b1, delay, 1'b0};
		else
		begin
			eng_done <= run && cnt == 4'h0;
			eng_ok <= (run && cnt == 4'h0) ? pass : ~eng_ok;
			run <= run && cnt != 4'h0;
			cnt <= cnt - 4'h1;
		end
	end
endmodule
`default_nettype wire

/* tb/crd_top_chk.sv */
// Port-level assertions for the crypto request decoder top
`timescale 1ns/1ps
`default_nettype none
`include "crd_consts.svh"
module crd_top_chk
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic eng_start,
	input wire logic [2:0] eng_service,
	input wire logic [31:0] eng_src_len,
	input wire logic [31:0] eng_res_off
);
	// ----------------------------------------
	// Bus and engine properties
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Control write that launches a data command
	logic go;
	assign go = avs_write && !avs_waitrequest && avs_address == `CRD_OFF_CTRL
		&& avs_writedata[2:0] == 3'h7;
	sequence bus_req;
		(avs_read || avs_write) && avs_waitrequest && ce;
	endsequence
	sequence rd_done(logic [7:0] a);
		avs_read && !avs_waitrequest && avs_address == a;
	endsequence
	wait_one_a: assert property (bus_req |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	wait_short_a: assert property (!avs_waitrequest && ce |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	wait_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
		else $error("answer without a request");
	start_cause_a: assert property (eng_start |-> $past(go, 1) || $past(go, 2) || $past(go, 3))
		else $error("engine start without a data command");
	start_pulse_a: assert property (eng_start |=> !eng_start)
		else $error("engine start longer than one cycle");
	hash_off_a: assert property (eng_start && eng_service == 3'h1 |-> eng_res_off == eng_src_len)
		else $error("hash result area not right after source");
	pad_zero_a: assert property (avs_read && !avs_waitrequest && (avs_address == `CRD_OFF_PAD
		|| avs_address > `CRD_OFF_SUPPORT) |-> avs_readdata == 32'h0)
		else $error("padding or unmapped read not zero");
	status_code_a: assert property (rd_done(`CRD_OFF_STATUS) |->
		avs_readdata[31:10] == 22'h0 && avs_readdata[7:0] <= `CRD_ST_NOSPC)
		else $error("status word out of range");
	layout_len_a: assert property (rd_done(`CRD_OFF_LAYOUT) |-> avs_readdata[7:0] inside
		{`CRD_FLF_HASH, `CRD_FLF_HASH_SL, `CRD_FLF_LEGACY})
		else $error("fixed block length not a legal size");
endmodule
bind crd_top crd_top_chk chk (.clk(clk), .rst(rst), .ce(ce), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .eng_start(eng_start),
	.eng_service(eng_service), .eng_src_len(eng_src_len), .eng_res_off(eng_res_off));
`default_nettype wire

/* tb/crypto_request_decoder_test.sv */
// Self-checking bench for the crypto request decoder
`timescale 1ns/1ps
`default_nettype none
`include "crd_consts.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
	$display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end
module crypto_request_decoder_test;
	// ----------------------------------------
	// Stimulus, design and engine
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] adr = 8'h0;
	logic rd_r = 1'b0;
	logic wr_r = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0] be = 4'hf;
	logic [3:0] dly = 4'h0;
	logic pass = 1'b1;
	logic [31:0] avs_readdata, eng_algo, eng_src_len, eng_res_len, eng_res_off;
	logic avs_waitrequest, eng_start, eng_done, eng_ok;
	logic [2:0] eng_service;
	logic [98:0] cap;
	logic [63:0] h [9];
	logic [5:0] feat = 6'h0;
	logic [4:0][1:0] mx = {2'd3, 2'd1, 2'd0, 2'd0, 2'd1};
	int miscompares = 0;
	int n_tests = 0;
	int cyc = 0;
	int nstart = 0;
	always #2.5 clk = ~clk;
	crd_top dut (.clk(clk), .rst(rst), .ce(ce), .avs_address(adr), .avs_read(rd_r),
		.avs_write(wr_r), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .eng_start(eng_start), .eng_service(eng_service),
		.eng_algo(eng_algo), .eng_src_len(eng_src_len), .eng_res_len(eng_res_len),
		.eng_res_off(eng_res_off), .eng_done(eng_done), .eng_ok(eng_ok));
	crd_eng_model eng (.clk(clk), .rst(rst), .eng_start(eng_start), .delay(dly), .pass(pass),
		.eng_done(eng_done), .eng_ok(eng_ok));
	// Snapshot of each engine request; hang guard
	always @(posedge clk)
	begin
		if (eng_start === 1'b1)
		begin
			nstart++;
			cap <= {eng_service, eng_src_len, eng_res_len, eng_res_off};
		end
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------
	// Expectations and bus tasks
	// ----------------------------------------
	function automatic logic [7:0] exp_len(input logic [5:0] f, input logic [2:0] s);
		if (s > 3'h2 || s == 3'h0)
			return `CRD_FLF_OTHER;
		if (f[s + 3'h1])
			return `CRD_FLF_HASH_SL;
		return f[0] ? `CRD_FLF_HASH : `CRD_FLF_LEGACY;
	endfunction
	function automatic logic [98:0] exp_eng(input logic [5:0] f, input logic [2:0] s,
		input logic [3:0][31:0] w);
		if (f[s + 3'h1] && s == 3'h2)
			return {s, w[2], w[3], w[1] + w[2]};
		if (f[s + 3'h1])
			return {s, w[1], w[2], w[1]};
		return {s, w[0], w[1], w[0]};
	endfunction
	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		adr <= a;
		wd <= d;
		rd_r <= !w;
		wr_r <= w;
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		rd_r <= 1'b0;
		wr_r <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask
	task automatic setf(input logic [5:0] v);
		feat = v;
		wr(`CRD_OFF_FEAT, {26'h0, v});
	endtask
	// Start a command and poll until it is no longer busy
	task automatic cmd(input logic [1:0] c, output logic [7:0] st);
		logic [31:0] q;
		wr(`CRD_OFF_CTRL, {29'h0, c, 1'b1});
		q = 32'h100;
		while (q[8] !== 1'b0)
			rd(`CRD_OFF_STATUS, q);
		`CHK(q[9], 1'b1)
		st = q[7:0];
	endtask
	task automatic dst(input logic [31:0] opc, input logic [63:0] hd, input logic [7:0] est);
		logic [7:0] st;
		wr(`CRD_OFF_OPCODE, opc);
		wr(`CRD_OFF_HND_LO, hd[31:0]);
		wr(`CRD_OFF_HND_HI, hd[63:32]);
		cmd(`CRD_CMD_DESTROY, st);
		`CHK(st, est)
	endtask
	// Data request with random lengths and reserved word
	task automatic dat(input logic [31:0] opc, input logic [31:0] flg, input logic [63:0] hd,
		input logic [7:0] est);
		logic [3:0][31:0] w;
		logic [31:0] q;
		logic [7:0] st;
		int n0;
		w = {$urandom(), $urandom_range(4096, 1), $urandom_range(64, 1), $urandom_range(4096, 1)};
		wr(`CRD_OFF_OPCODE, opc);
		wr(`CRD_OFF_ALGO, w[3]);
		wr(`CRD_OFF_FLAG, flg);
		wr(`CRD_OFF_HND_LO, hd[31:0]);
		wr(`CRD_OFF_HND_HI, hd[63:32]);
		for (int i = 0; i < 4; i++)
			wr(`CRD_OFF_FLF0 + 8'(4 * i), w[i]);
		n0 = nstart;
		cmd(`CRD_CMD_DATA, st);
		`CHK(st, est)
		`CHK(eng_algo, w[3])
		`CHK(nstart - n0, int'(est == `CRD_ST_OK || !pass))
		if (nstart != n0)
		begin
			rd(`CRD_OFF_LAYOUT, q);
			`CHK(q[12:0], {flg == 32'h1 || !feat[0], opc[10:8], feat[opc[10:8] + 3'h1],
				exp_len(feat, opc[10:8])})
			if (opc[10:8] inside {3'h1, 3'h2})
				`CHK(cap, exp_eng(feat, opc[10:8], w))
		end
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] q;
		logic [7:0] st;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		void'($urandom(23405));
		rd(`CRD_OFF_FEAT, q);
		`CHK(q[5:0], `CRD_RST_FEAT)
		rd(`CRD_OFF_SUPPORT, q);
		`CHK(q[4:0], `CRD_RST_SUPPORT)
		rd(`CRD_OFF_STATUS, q);
		`CHK(q[7:0], `CRD_RST_STATUS)
		setf(6'h01);
		// Fill the session table, then one too many
		for (int i = 0; i < 9; i++)
		begin
			wr(`CRD_OFF_OPCODE, 32'(i % 5) << 8);
			cmd(`CRD_CMD_CREATE, st);
			`CHK(st, (i < 8) ? `CRD_ST_OK : `CRD_ST_NOSPC)
			rd(`CRD_OFF_NEW_LO, q);
			h[i][31:0] = q;
			rd(`CRD_OFF_NEW_HI, q);
			h[i][63:32] = q;
			for (int j = 0; j < i; j++)
				`CHK(h[i] == h[j], i == 8 && j == 7)
		end
		setf(6'h00);
		cmd(`CRD_CMD_CREATE, st);
		`CHK(st, `CRD_ST_ERR)
		setf(6'h01);
		wr(`CRD_OFF_OPCODE, 32'h500);
		cmd(`CRD_CMD_CREATE, st);
		`CHK(st, `CRD_ST_NOTSUPP)
		wr(`CRD_OFF_SUPPORT, 32'h1b);
		wr(`CRD_OFF_OPCODE, 32'h200);
		cmd(`CRD_CMD_CREATE, st);
		`CHK(st, `CRD_ST_NOTSUPP)
		wr(`CRD_OFF_SUPPORT, 32'h1f);
		dst(32'h000, h[5], `CRD_ST_OK);
		dst(32'h000, h[5], `CRD_ST_ERR);
		dst(32'h200, h[6], `CRD_ST_ERR);
		// Every operation index of every service, one past the last
		for (int s = 0; s < 5; s++)
			for (int x = 0; x <= mx[s] + 1; x++)
				dat(32'(s * 256 + x), 32'h1, h[s], (x <= mx[s]) ? `CRD_ST_OK : `CRD_ST_NOTSUPP);
		dat(32'h10100, 32'h1, h[1], `CRD_ST_NOTSUPP);
		dat(32'h100, 32'h0, h[1], `CRD_ST_ERR);
		dat(32'h100, 32'h1, h[5], `CRD_ST_INVSESS);
		repeat (4)
		begin
			dly <= 4'($urandom_range(15, 0));
			q = $urandom_range(2, 1);
			dat(q << 8, 32'h1, h[q], `CRD_ST_OK);
		end
		pass <= 1'b0;
		dly <= 4'hf;
		dat(32'h100, 32'h1, h[1], `CRD_ST_ERR);
		pass <= 1'b1;
		setf(6'h00);
		dat(32'h100, 32'h0, h[1], `CRD_ST_OK);
		setf(6'h0d);
		dat(32'h100, 32'h0, 64'h0, `CRD_ST_OK);
		dat(32'h200, 32'h0, 64'h0, `CRD_ST_OK);
		wr(`CRD_OFF_PAD, $urandom());
		rd(`CRD_OFF_PAD, q);
		`CHK(q, 32'h0)
		wr(8'h60, $urandom());
		rd(8'h60, q);
		`CHK(q, 32'h0)
		tally_and_finish();
	end
endmodule
`default_nettype wire
